// *** core/tcb_pkg.sv ***
// Package for the trackpad configuration bank: addresses, masks, resets and carriers.
// Assumes a byte-wide register port with 16-bit addresses, one byte per address.
package tcb_pkg;

    localparam logic [15:0] TCB_ADDR_POS      = 16'h11E2;
    localparam logic [15:0] TCB_ADDR_ONE_LO   = 16'h11F6;
    localparam logic [15:0] TCB_ADDR_ONE_HI   = 16'h11F7;
    localparam logic [15:0] TCB_ADDR_TWO_LO   = 16'h11F8;
    localparam logic [15:0] TCB_ADDR_TWO_HI   = 16'h11F9;
    localparam logic [15:0] TCB_ADDR_MAP_BASE = 16'h1218;
    localparam logic [15:0] TCB_ADDR_MAP_LAST = 16'h1244;
    localparam logic [15:0] TCB_ADDR_MAP_SPR  = 16'h1245;
    localparam logic [15:0] TCB_ADDR_THR_BASE = 16'h12F6;
    localparam logic [15:0] TCB_ADDR_THR_LAST = 16'h14EF;

    localparam int          TCB_MAP_DEPTH     = 45;
    localparam int          TCB_THR_DEPTH     = 506;

    localparam logic [7:0]  TCB_POS_RST       = 8'h00;
    localparam logic [15:0] TCB_ONE_RST       = 16'h0000;
    localparam logic [15:0] TCB_TWO_RST       = 16'h0000;
    localparam logic [7:0]  TCB_MAP_RST       = 8'h00;
    localparam logic [7:0]  TCB_THR_RST       = 8'h00;
    localparam logic [7:0]  TCB_SPARE_VAL     = 8'h00;
    localparam logic [7:0]  TCB_UNMAPPED_VAL  = 8'h00;

    localparam logic [7:0]  TCB_POS_MASK      = 8'h7F;
    localparam logic [15:0] TCB_ONE_MASK      = 16'hFF1F;
    localparam logic [15:0] TCB_TWO_MASK      = 16'h00FF;

    // Position settings byte, bit 7 down to bit 0
    typedef struct packed {
        logic unused;
        logic area_filter_off;
        logic jitter_filter_on;
        logic fixed_damping_select;
        logic recursive_smoothing_on;
        logic axis_swap;
        logic invert_y;
        logic invert_x;
    } tcb_pos_t;

    // One-finger enables; direction nibbles are Y-, Y+, X-, X+
    typedef struct packed {
        logic [3:0] swipe_hold;
        logic [3:0] swipe;
        logic [2:0] unused;
        logic       palm;
        logic       press_hold;
        logic       triple_tap;
        logic       double_tap;
        logic       single_tap;
    } tcb_one_t;

    typedef struct packed {
        logic [7:0] unused;
        logic       scroll_h;
        logic       scroll_v;
        logic       zoom_out;
        logic       zoom_in;
        logic       press_hold;
        logic       triple_tap;
        logic       double_tap;
        logic       single_tap;
    } tcb_two_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } tcb_req_t;

endpackage : tcb_pkg

// *** core/tcb_bank.sv ***
// Configuration register bank: position settings, gesture enables, electrode slot map
// and per-channel signed threshold offsets, plus lookup ports for the sensing engines.
// Assumes the serial port front end delivers one byte access per request, synchronous to clk_sys.
//
// What this block does
// - Bit 6 set turns area filter off
// - Bit 5 set turns jitter filter on
// - Bit 4 set fixes smoothing damping factor
// - Bit 3 set applies recursive smoothing filter
// - Bit 2 set swaps column and row electrodes
// - Bit 1 set inverts reported Y
// - Bit 0 set inverts reported X
// - One-finger bits 15-12 enable swipe-and-hold directions
// - One-finger bits 11-8 enable swipe directions
// - One-finger bits 4-0 palm/hold/taps; 7-5 unused
// - Two-finger bits 7-6 scroll; 15-8 unused
// - Two-finger bits 5-0 zoom, hold, taps
// - Slot map 0x1218-0x1244; 0x1245 reserved zero
// - 506 threshold offset bytes from 0x12F6
// - Offset is signed, added to threshold multiplier
`timescale 1ns/1ps
module tcb_bank
    import tcb_pkg::*;
#(
    parameter int MAP_DEPTH = TCB_MAP_DEPTH,
    parameter int THR_DEPTH = TCB_THR_DEPTH
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire tcb_req_t    req,
    output logic [7:0]       rdata,
    output logic             rvalid,
    output tcb_pos_t         pos_cfg,
    output tcb_one_t         one_en,
    output tcb_two_t         two_en,
    input  wire logic [5:0]  eng_slot,
    output logic [7:0]       eng_map,
    input  wire logic [8:0]  eng_ch,
    input  wire logic [7:0]  eng_mult,
    output logic signed [9:0] eng_thr
);

    tcb_pos_t          pos_r;
    tcb_one_t          one_r;
    tcb_two_t          two_r;
    logic [7:0]        map_r [MAP_DEPTH];
    logic [7:0]        thr_r [THR_DEPTH];
    logic [7:0]        rdata_r;
    logic [7:0]        rdata_nxt;
    logic              rvalid_r;
    logic [7:0]        eng_map_r;
    logic signed [9:0] eng_thr_r;
    logic              map_hit;
    logic              thr_hit;
    logic [5:0]        map_idx;
    logic [8:0]        thr_idx;

    assign map_hit = (req.addr >= TCB_ADDR_MAP_BASE) && (req.addr <= TCB_ADDR_MAP_LAST);
    assign thr_hit = (req.addr >= TCB_ADDR_THR_BASE) && (req.addr <= TCB_ADDR_THR_LAST);
    assign map_idx = 6'(req.addr - TCB_ADDR_MAP_BASE);
    assign thr_idx = 9'(req.addr - TCB_ADDR_THR_BASE);

    // Position settings byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pos_r <= tcb_pos_t'(TCB_POS_RST);
        end else if (req.wr && req.addr == TCB_ADDR_POS) begin
            pos_r <= tcb_pos_t'(req.wdata & TCB_POS_MASK);
        end
    end

    // One-finger gesture enables, low byte at the even address
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            one_r <= tcb_one_t'(TCB_ONE_RST);
        end else if (req.wr && req.addr == TCB_ADDR_ONE_LO) begin
            one_r[7:0] <= req.wdata & TCB_ONE_MASK[7:0];
        end else if (req.wr && req.addr == TCB_ADDR_ONE_HI) begin
            one_r[15:8] <= req.wdata & TCB_ONE_MASK[15:8];
        end
    end

    // Two-finger gesture enables
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            two_r <= tcb_two_t'(TCB_TWO_RST);
        end else if (req.wr && req.addr == TCB_ADDR_TWO_LO) begin
            two_r[7:0] <= req.wdata & TCB_TWO_MASK[7:0];
        end else if (req.wr && req.addr == TCB_ADDR_TWO_HI) begin
            two_r[15:8] <= req.wdata & TCB_TWO_MASK[15:8];
        end
    end

    // Electrode slot map; the spare byte after it is never stored
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < MAP_DEPTH; i++) begin
                map_r[i] <= TCB_MAP_RST;
            end
        end else if (req.wr && map_hit) begin
            map_r[map_idx] <= req.wdata;
        end
    end

    // Per-channel threshold offsets
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < THR_DEPTH; i++) begin
                thr_r[i] <= TCB_THR_RST;
            end
        end else if (req.wr && thr_hit) begin
            thr_r[thr_idx] <= req.wdata;
        end
    end

    // Read decode; unmapped and reserved addresses answer zero
    always_comb begin
        rdata_nxt = TCB_UNMAPPED_VAL;
        if (req.addr == TCB_ADDR_POS) begin
            rdata_nxt = pos_r;
        end else if (req.addr == TCB_ADDR_ONE_LO) begin
            rdata_nxt = one_r[7:0];
        end else if (req.addr == TCB_ADDR_ONE_HI) begin
            rdata_nxt = one_r[15:8];
        end else if (req.addr == TCB_ADDR_TWO_LO) begin
            rdata_nxt = two_r[7:0];
        end else if (req.addr == TCB_ADDR_TWO_HI) begin
            rdata_nxt = two_r[15:8];
        end else if (map_hit) begin
            rdata_nxt = map_r[map_idx];
        end else if (req.addr == TCB_ADDR_MAP_SPR) begin
            rdata_nxt = TCB_SPARE_VAL;
        end else if (thr_hit) begin
            rdata_nxt = thr_r[thr_idx];
        end
    end

    // Read answer, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= req.rd;
            if (req.rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Engine lookups; out-of-range slots give zero, out-of-range channels give the multiplier without offset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eng_map_r <= 8'h00;
            eng_thr_r <= 10'sh000;
        end else begin
            eng_map_r <= (32'(eng_slot) < MAP_DEPTH) ? map_r[eng_slot] : 8'h00;
            if (32'(eng_ch) < THR_DEPTH) begin
                eng_thr_r <= $signed({2'b00, eng_mult}) + $signed({{2{thr_r[eng_ch][7]}}, thr_r[eng_ch]});
            end else begin
                eng_thr_r <= $signed({2'b00, eng_mult});
            end
        end
    end

    assign rdata   = rdata_r;
    assign rvalid  = rvalid_r;
    assign pos_cfg = pos_r;
    assign one_en  = one_r;
    assign two_en  = two_r;
    assign eng_map = eng_map_r;
    assign eng_thr = eng_thr_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_pos_write;
        req.wr && req.addr == TCB_ADDR_POS;
    endsequence

    property p_pos_bits;
        s_pos_write |=> pos_cfg[6:0] == $past(req.wdata[6:0]) && !pos_cfg.unused;
    endproperty
    a_pos_bits: assert property (p_pos_bits) else $error("position settings not taken");

    property p_axis_swap;
        s_pos_write ##1 !(req.wr && req.addr == TCB_ADDR_POS) |=> $stable(pos_cfg.axis_swap);
    endproperty
    a_axis_swap: assert property (p_axis_swap) else $error("axis swap changed without write");

    property p_pos_read;
        req.rd && !req.wr && req.addr == TCB_ADDR_POS |=> rvalid && rdata == {1'b0, pos_cfg[6:0]};
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("position read wrong");

    property p_one_lo_unused;
        req.rd && req.addr == TCB_ADDR_ONE_LO |=> rdata[7:5] == 3'h0;
    endproperty
    a_one_lo_unused: assert property (p_one_lo_unused) else $error("one-finger unused bits nonzero");

    property p_one_hi;
        req.wr && req.addr == TCB_ADDR_ONE_HI |=> one_en[15:8] == $past(req.wdata);
    endproperty
    a_one_hi: assert property (p_one_hi) else $error("swipe enables not taken");

    property p_two_hi_zero;
        req.rd && req.addr == TCB_ADDR_TWO_HI |=> rdata == 8'h00 && two_en.unused == 8'h00;
    endproperty
    a_two_hi_zero: assert property (p_two_hi_zero) else $error("two-finger unused bits nonzero");

    property p_spare_zero;
        req.rd && req.addr == TCB_ADDR_MAP_SPR |=> rdata == TCB_SPARE_VAL;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare map byte nonzero");

    property p_jitter_bit;
        s_pos_write |=> pos_cfg.jitter_filter_on == $past(req.wdata[5]);
    endproperty
    a_jitter_bit: assert property (p_jitter_bit) else $error("jitter filter bit not taken");

    property p_damping_bit;
        s_pos_write |=> pos_cfg.fixed_damping_select == $past(req.wdata[4]);
    endproperty
    a_damping_bit: assert property (p_damping_bit) else $error("damping select bit not taken");

    property p_smoothing_bit;
        s_pos_write |=> pos_cfg.recursive_smoothing_on == $past(req.wdata[3]);
    endproperty
    a_smoothing_bit: assert property (p_smoothing_bit) else $error("smoothing bit not taken");

    property p_invert_y_bit;
        s_pos_write |=> pos_cfg.invert_y == $past(req.wdata[1]);
    endproperty
    a_invert_y_bit: assert property (p_invert_y_bit) else $error("invert Y bit not taken");

    property p_invert_x_bit;
        s_pos_write |=> pos_cfg.invert_x == $past(req.wdata[0]);
    endproperty
    a_invert_x_bit: assert property (p_invert_x_bit) else $error("invert X bit not taken");

    property p_pos_hold;
        !(req.wr && req.addr == TCB_ADDR_POS) |=> $stable(pos_cfg);
    endproperty
    a_pos_hold: assert property (p_pos_hold) else $error("position settings changed without write");

    property p_swipe_bits;
        req.wr && req.addr == TCB_ADDR_ONE_HI |=> one_en.swipe == $past(req.wdata[3:0]);
    endproperty
    a_swipe_bits: assert property (p_swipe_bits) else $error("swipe enables not taken");

    property p_one_lo;
        req.wr && req.addr == TCB_ADDR_ONE_LO |=> one_en[4:0] == $past(req.wdata[4:0]) && one_en.unused == 3'h0;
    endproperty
    a_one_lo: assert property (p_one_lo) else $error("one-finger low enables wrong");

    property p_scroll_bits;
        req.wr && req.addr == TCB_ADDR_TWO_LO |=> {two_en.scroll_h, two_en.scroll_v} == $past(req.wdata[7:6]);
    endproperty
    a_scroll_bits: assert property (p_scroll_bits) else $error("scroll enables not taken");

    property p_two_lo;
        req.wr && req.addr == TCB_ADDR_TWO_LO |=> two_en[5:0] == $past(req.wdata[5:0]);
    endproperty
    a_two_lo: assert property (p_two_lo) else $error("two-finger enables not taken");

    property p_map_last;
        req.wr && req.addr == TCB_ADDR_MAP_LAST |=> map_r[MAP_DEPTH-1] == $past(req.wdata);
    endproperty
    a_map_last: assert property (p_map_last) else $error("last slot map byte not stored");

    property p_eng_map_oob;
        32'(eng_slot) >= MAP_DEPTH |=> eng_map == 8'h00;
    endproperty
    a_eng_map_oob: assert property (p_eng_map_oob) else $error("slot lookup beyond table nonzero");

    property p_thr_last;
        req.wr && req.addr == TCB_ADDR_THR_LAST |=> thr_r[THR_DEPTH-1] == $past(req.wdata);
    endproperty
    a_thr_last: assert property (p_thr_last) else $error("last threshold offset not stored");

    property p_thr_oob;
        32'(eng_ch) >= THR_DEPTH |=> eng_thr == $signed({2'b00, $past(eng_mult)});
    endproperty
    a_thr_oob: assert property (p_thr_oob) else $error("channel beyond table changed threshold");

    property p_unmapped_read;
        req.rd && !req.wr && req.addr > TCB_ADDR_THR_LAST |=> rvalid && rdata == TCB_UNMAPPED_VAL;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

    sequence s_thr_write_read;
        req.wr && !req.rd && thr_hit ##1 !req.wr ##1 req.rd && !req.wr && req.addr == $past(req.addr, 2);
    endsequence

    property p_thr_readback;
        s_thr_write_read |=> rvalid && rdata == $past(req.wdata, 3);
    endproperty
    a_thr_readback: assert property (p_thr_readback) else $error("threshold offset readback wrong");

    property p_thr_sign;
        eng_ch == 9'h000 && thr_r[0] == 8'h80 && eng_mult == 8'h80 |=> eng_thr == 10'sh000;
    endproperty
    a_thr_sign: assert property (p_thr_sign) else $error("signed offset not applied");

endmodule : tcb_bank

// *** dv/tcb_host_model.sv ***
// Host model: drives byte accesses on the bank's register port.
// Assumes the bank samples req on the rising edge of clk_sys.
`timescale 1ns/1ps
module tcb_host_model
    import tcb_pkg::*;
(
    input  wire logic     clk_sys,
    output tcb_req_t      req
);
    initial req = '0;

    // One access per call; the released bus shows inverted values
    task automatic send(input logic w, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (w && a >= TCB_ADDR_MAP_BASE && a <= TCB_ADDR_MAP_LAST && d == 8'h2C) v = 8'h2D;
        @(negedge clk_sys);
        req <= '{wr: w, rd: !w, addr: a, wdata: v};
        @(negedge clk_sys);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask : send
endmodule : tcb_host_model

// *** dv/test_tcb_bank.sv ***
// Self-checking bench for the configuration bank.
// Assumes all-zero reset values and one-cycle read latency.
`timescale 1ns/1ps
module test_tcb_bank;
    import tcb_pkg::*;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
    logic            clk_sys, rst, rvalid;
    tcb_req_t        req;
    logic [7:0]      rdata, eng_map, eng_mult, d, ev;
    tcb_pos_t        pos_cfg;
    tcb_one_t        one_en;
    tcb_two_t        two_en;
    logic [5:0]      eng_slot;
    logic [8:0]      eng_ch;
    logic signed [9:0] eng_thr, e;
    logic [15:0]     w;
    logic [7:0]      m [45];
    logic [7:0]      expq [$];
    logic [31:0]     seed = 32'd89932;
    int              bad_count = 0, n_tests = 0, cyc = 0;
    logic [8:0]      chs [4] = '{9'd0, 9'd5, 9'd505, 9'd506};
    logic [7:0]      offs [4] = '{8'h80, 8'hFF, 8'h7F, 8'h11};

    tcb_host_model u_tcb_host_model (.clk_sys(clk_sys), .req(req));
    tcb_bank u_tcb_bank (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid),
        .pos_cfg(pos_cfg), .one_en(one_en), .two_en(two_en), .eng_slot(eng_slot), .eng_map(eng_map),
        .eng_ch(eng_ch), .eng_mult(eng_mult), .eng_thr(eng_thr));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task automatic wr(input logic [15:0] a, input logic [7:0] dv);
        u_tcb_host_model.send(1'b1, a, dv);
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] ex);
        expq.push_back(ex);
        u_tcb_host_model.send(1'b0, a, 8'h00);
    endtask : rd

    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    always @(negedge clk_sys) begin
        if (rvalid === 1'b1) begin
            ev = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
            `CHK("rdata", ev, rdata)
        end
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("Error timeout exp done got stuck");
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        eng_slot = 6'h00;
        eng_ch = 9'h000;
        eng_mult = 8'h00;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        rd(TCB_ADDR_POS, TCB_POS_RST);
        rd(TCB_ADDR_ONE_HI, TCB_ONE_RST[15:8]);
        for (int i = 0; i < 9; i++) begin
            if (i < 8) d = 8'h01 << i;
            else d = rnd();
            wr(TCB_ADDR_POS, d);
            `CHK("pos_cfg", d & TCB_POS_MASK, pos_cfg)
            rd(TCB_ADDR_POS, d & TCB_POS_MASK);
        end
        for (int i = 0; i < 16; i++) begin
            w = 16'h0001 << i;
            wr(TCB_ADDR_ONE_LO, w[7:0]);
            wr(TCB_ADDR_ONE_HI, w[15:8]);
            wr(TCB_ADDR_TWO_LO, w[7:0]);
            wr(TCB_ADDR_TWO_HI, w[15:8]);
            `CHK("one_en", w & TCB_ONE_MASK, one_en)
            `CHK("two_en", w & TCB_TWO_MASK, two_en)
            rd(TCB_ADDR_ONE_HI, w[15:8] & TCB_ONE_MASK[15:8]);
            rd(TCB_ADDR_TWO_HI, 8'h00);
            rd(TCB_ADDR_ONE_LO, w[7:0] & TCB_ONE_MASK[7:0]);
            rd(TCB_ADDR_TWO_LO, w[7:0]);
        end
        for (int i = 0; i < 45; i++) begin
            d = rnd();
            m[i] = (d == 8'h2C) ? 8'h2D : d;
            wr(TCB_ADDR_MAP_BASE + 16'(i), m[i]);
        end
        for (int i = 0; i < 46; i++) begin
            eng_slot = 6'(i);
            @(negedge clk_sys);
            `CHK("eng_map", (i < 45) ? m[i] : 8'h00, eng_map)
        end
        rd(TCB_ADDR_MAP_BASE, m[0]);
        rd(TCB_ADDR_MAP_LAST, m[44]);
        wr(TCB_ADDR_MAP_SPR, 8'hFF);
        rd(TCB_ADDR_MAP_SPR, TCB_SPARE_VAL);
        for (int k = 0; k < 4; k++) begin
            wr(TCB_ADDR_THR_BASE + 16'(chs[k]), offs[k]);
            rd(TCB_ADDR_THR_BASE + 16'(chs[k]), (k < 3) ? offs[k] : TCB_UNMAPPED_VAL);
            d = (k == 0) ? 8'h80 : rnd();
            eng_ch = chs[k];
            eng_mult = d;
            @(negedge clk_sys);
            e = $signed({2'b00, d}) + ((k < 3) ? $signed({{2{offs[k][7]}}, offs[k]}) : 10'sh000);
            `CHK("eng_thr", e, eng_thr)
        end
        repeat (4) @(negedge clk_sys);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        `CHK("pos_cfg_rst", TCB_POS_RST, pos_cfg)
        `CHK("one_en_rst", TCB_ONE_RST, one_en)
        rd(TCB_ADDR_MAP_LAST, TCB_MAP_RST);
        rd(TCB_ADDR_THR_LAST, TCB_THR_RST);
        repeat (4) @(negedge clk_sys);
        `CHK("reads_left", 0, expq.size())
        wrap_up();
    end
endmodule : test_tcb_bank
